// ### logic/program_memory_table_read_defines.svh
`ifndef PROGRAM_MEMORY_TABLE_READ_DEFINES_SVH
`define PROGRAM_MEMORY_TABLE_READ_DEFINES_SVH

// program store geometry
`define PM_DEPTH 14'h2000
`define PM_AW 5'h0D
`define PM_DW 5'h10
`define PC_RESET 13'h0000
`define LAST_PAGE 5'h1F
`define HIGH_BYTE_MASK 8'hFF
`define SECTOR0 1'b0

// serial programming frame: cmd, 13 address bits, 16 data bits
`define FRAME_HDR_BITS 5'h0E
`define FRAME_ALL_BITS 5'h1E
`define CMD_WRITE 1'b1

`endif

// ### logic/pmem_pkg.sv
package pmem_pkg;
    typedef enum logic [2:0] {
        TBL_NONE = 3'b000,
        TBL_RD = 3'b001,
        TBL_RD_LAST = 3'b010,
        TBL_RD_EXT = 3'b011,
        TBL_RD_EXT_LAST = 3'b100
    } tblop_e;

    typedef struct packed {
        logic valid;
        tblop_e op;
        logic [8:0] dest;
    } tblReq_s;

    typedef struct packed {
        logic en;
        logic [8:0] addr;
        logic [7:0] data;
    } dmWrite_s;

    typedef enum logic [0:0] {
        TS_IDLE = 1'b0,
        TS_WRITE = 1'b1
    } tblState_e;
endpackage

// ### logic/program_memory_table_read.sv
// Notes on behaviour
// [R1] The program store holds 8K words of 16 bits: code, tables, entries.
// [R2] After any reset the instruction fetch starts at word 000H.
// [R3] A paged table read is addressed by the high and low table pointers.
// [R4] A table read writes the low byte of the word to the operand location.
// [R5] A table read loads the high byte into table_high_byte, spare bits 0.
// [R6] Standard reads target sector 0 only; extended reads reach any sector.
// [R7] Every table read completes in exactly two cycles.
// [R8] Software can read and write table_high_byte to save and restore it.
// [R9] Last-page reads use page 1F00H plus the low pointer only.
// [R10] Programming moves data serially on one two-way line and a clock.
// [R11] The debug pins, clock in and two-way data, also serve for programming.
// [R12] The program counter is 13 bits: five high bits over pc_low_byte.
// [R13] The store is read in the first cycle; both writes land in the second.
`timescale 1ns/1ps
`include "program_memory_table_read_defines.svh"

module program_memory_table_read (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // program counter control from the core
    input wire logic pcAdvance,
    input wire logic pcLoad,
    input wire logic [12:0] pcLoadValue,
    output logic [12:0] pc_q,
    output logic [15:0] instrWord_q,
    // table read requests and pointers
    input wire pmem_pkg::tblReq_s tblReq,
    input wire logic [7:0] tblPtrLow,
    input wire logic [7:0] tblPtrHigh,
    output logic tblBusy_q,
    output pmem_pkg::dmWrite_s dmWr_q,
    // table_high_byte software access
    input wire logic highByteWrEn,
    input wire logic [7:0] highByteWrData,
    output logic [7:0] tableHighByte_q,
    // serial programming and debug pins
    input wire logic progMode,
    input wire logic useDebugPins,
    input wire logic prog_serial_clock,
    input wire logic prog_serial_data_in,
    input wire logic debug_serial_clock,
    input wire logic debug_serial_data_in,
    output logic serialDataOut_q,
    output logic serialDataOe_q
);
    import pmem_pkg::*;

    // ------------------------------------------------------------
    // program store
    // ------------------------------------------------------------
    logic [15:0] store [0:`PM_DEPTH-1]; // R1
    logic [12:0] tblAddr;
    logic tblAccept;
    logic progWrite;
    logic [12:0] progAddr_q;
    logic [15:0] progShift_q;
    logic [15:0] progWord;

    function automatic logic isExt(input tblop_e op);
        return (op == TBL_RD_EXT) || (op == TBL_RD_EXT_LAST);
    endfunction

    function automatic logic isLast(input tblop_e op);
        return (op == TBL_RD_LAST) || (op == TBL_RD_EXT_LAST);
    endfunction

    always_comb begin
        if (isLast(tblReq.op)) begin
            tblAddr = {`LAST_PAGE, tblPtrLow}; // R9
        end else begin
            tblAddr = {tblPtrHigh[4:0], tblPtrLow}; // R3
        end
    end

    always_ff @(posedge clk) begin
        if (progWrite) begin
            // last data bit arrives with the write strobe itself
            store[progAddr_q] <= progWord; // R10
        end
    end

    // ------------------------------------------------------------
    // program counter and instruction fetch
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pc_q <= `PC_RESET; // R2
        end else if (pcLoad) begin
            pc_q <= pcLoadValue; // R12
        end else if (pcAdvance) begin
            pc_q <= pc_q + 13'h0001; // R12
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            instrWord_q <= 16'h0000;
        end else begin
            instrWord_q <= store[pc_q]; // R1
        end
    end

    // ------------------------------------------------------------
    // table read sequencer
    // ------------------------------------------------------------
    tblState_e state_q;
    logic [15:0] tblWord_q;
    logic [8:0] tblDest_q;

    assign tblAccept = (state_q == TS_IDLE) && tblReq.valid
        && (tblReq.op != TBL_NONE);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= TS_IDLE;
            tblBusy_q <= 1'b0;
        end else begin
            case (state_q)
                TS_IDLE: begin
                    if (tblAccept) begin
                        state_q <= TS_WRITE; // R7
                        tblBusy_q <= 1'b1;
                    end
                end
                TS_WRITE: begin
                    state_q <= TS_IDLE; // R7
                    tblBusy_q <= 1'b0;
                end
                default: begin
                    state_q <= TS_IDLE;
                    tblBusy_q <= 1'b0;
                end
            endcase
        end
    end

    // store read in the first cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tblWord_q <= 16'h0000;
            tblDest_q <= 9'h000;
        end else if (tblAccept) begin
            tblWord_q <= store[tblAddr]; // R13
            if (isExt(tblReq.op)) begin
                tblDest_q <= tblReq.dest; // R6
            end else begin
                tblDest_q <= {`SECTOR0, tblReq.dest[7:0]}; // R6
            end
        end
    end

    // both byte writes in the second cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dmWr_q <= '0;
        end else begin
            dmWr_q.en <= (state_q == TS_WRITE); // R13
            dmWr_q.addr <= tblDest_q;
            dmWr_q.data <= tblWord_q[7:0]; // R4
        end
    end

    // hardware load wins over a software write in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tableHighByte_q <= 8'h00;
        end else if (state_q == TS_WRITE) begin
            tableHighByte_q <= tblWord_q[15:8] & `HIGH_BYTE_MASK; // R5
        end else if (highByteWrEn) begin
            tableHighByte_q <= highByteWrData; // R8
        end
    end

    // ------------------------------------------------------------
    // serial link
    // ------------------------------------------------------------
    logic [1:0] pClkSync_q;
    logic [1:0] pDatSync_q;
    logic [1:0] dClkSync_q;
    logic [1:0] dDatSync_q;
    logic [1:0] modeSync_q;
    logic linkClkPrev_q;
    logic linkClk;
    logic linkDat;
    logic linkRise;
    logic linkFall;
    logic [4:0] bitCnt_q;
    logic cmdWrite_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pClkSync_q <= 2'h0;
            pDatSync_q <= 2'h0;
            dClkSync_q <= 2'h0;
            dDatSync_q <= 2'h0;
            modeSync_q <= 2'h0;
        end else begin
            pClkSync_q <= {pClkSync_q[0], prog_serial_clock};
            pDatSync_q <= {pDatSync_q[0], prog_serial_data_in};
            dClkSync_q <= {dClkSync_q[0], debug_serial_clock};
            dDatSync_q <= {dDatSync_q[0], debug_serial_data_in};
            modeSync_q <= {modeSync_q[0], progMode};
        end
    end

    // emulation part: debug pins double as programming pins
    assign linkClk = useDebugPins ? dClkSync_q[1] : pClkSync_q[1]; // R11
    assign linkDat = useDebugPins ? dDatSync_q[1] : pDatSync_q[1]; // R11
    assign progWord = {progShift_q[14:0], linkDat};
    assign linkRise = linkClk && !linkClkPrev_q;
    assign linkFall = !linkClk && linkClkPrev_q;
    assign progWrite = linkRise && modeSync_q[1] && cmdWrite_q
        && (bitCnt_q == `FRAME_ALL_BITS - 5'h01);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            linkClkPrev_q <= 1'b0;
        end else begin
            linkClkPrev_q <= linkClk;
        end
    end

    // frame is ended by progMode, the link clock may stop between frames
    always_ff @(posedge clk) begin
        if (!rst_n || !modeSync_q[1]) begin
            bitCnt_q <= 5'h00;
            cmdWrite_q <= 1'b0;
            progAddr_q <= 13'h0000;
            progShift_q <= 16'h0000;
        end else if (linkRise && bitCnt_q != `FRAME_ALL_BITS) begin
            bitCnt_q <= bitCnt_q + 5'h01;
            if (bitCnt_q == 5'h00) begin
                cmdWrite_q <= linkDat; // R10
            end else if (bitCnt_q < `FRAME_HDR_BITS) begin
                progAddr_q <= {progAddr_q[11:0], linkDat};
            end else if (cmdWrite_q) begin
                progShift_q <= {progShift_q[14:0], linkDat};
            end
        end else if (bitCnt_q == `FRAME_HDR_BITS && !cmdWrite_q
            && progShift_q == 16'h0000) begin
            progShift_q <= store[progAddr_q];
        end
    end

    // read-back drives the shared line on falling clock edges
    always_ff @(posedge clk) begin
        if (!rst_n || !modeSync_q[1]) begin
            serialDataOut_q <= 1'b0;
            serialDataOe_q <= 1'b0;
        end else if (linkFall) begin
            serialDataOe_q <= !cmdWrite_q && bitCnt_q >= `FRAME_HDR_BITS
                && bitCnt_q < `FRAME_ALL_BITS; // R10
            serialDataOut_q <=
                progShift_q[4'(`FRAME_ALL_BITS - 5'h01 - bitCnt_q)]; // R10
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [7:0] expLow;
    logic [7:0] expHigh;
    logic [8:0] reqDest;
    logic reqExt;

    assign expLow = store[tblAddr][7:0];
    assign expHigh = store[tblAddr][15:8];
    assign reqDest = tblReq.dest;
    assign reqExt = isExt(tblReq.op);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_pc_reset_entry: assert property (disable iff (1'b0) // R2
        !rst_n |=> pc_q == 13'h0000) else $error("pc not at reset entry");
    a_tbl_two_cycles: assert property ( // R7
        tblAccept |=> (tblBusy_q && !dmWr_q.en)
        ##1 (dmWr_q.en && !tblBusy_q) ##1 !dmWr_q.en)
        else $error("table read not two cycles");
    a_tbl_low_byte: assert property ( // R4
        tblAccept |-> ##2 dmWr_q.data == $past(expLow, 2))
        else $error("wrong low byte written");
    a_tbl_high_byte: assert property ( // R5
        tblAccept |-> ##2 tableHighByte_q == $past(expHigh, 2))
        else $error("wrong high byte loaded");
    a_std_sector_zero: assert property ( // R6
        tblAccept && !reqExt |-> ##2 dmWr_q.addr[8] == 1'b0)
        else $error("standard read left sector 0");
    a_ext_any_sector: assert property ( // R6
        tblAccept && reqExt |-> ##2 dmWr_q.addr == $past(reqDest, 2))
        else $error("extended read wrong sector");
    a_last_page_addr: assert property ( // R9
        tblAccept && isLast(tblReq.op) |-> tblAddr[12:8] == 5'h1F)
        else $error("last page not used");
    a_paged_addr: assert property ( // R3
        tblAccept && !isLast(tblReq.op)
        |-> tblAddr == {tblPtrHigh[4:0], tblPtrLow})
        else $error("paged address wrong");
    a_high_byte_sw: assert property ( // R8
        highByteWrEn && state_q == TS_IDLE
        |=> tableHighByte_q == $past(highByteWrData))
        else $error("table high byte write lost");
    a_prog_oe_mode: assert property ( // R10
        serialDataOe_q |-> $past(modeSync_q[1]))
        else $error("line driven outside programming");

    c_std_read: cover property (tblAccept && tblReq.op == TBL_RD);
    c_ext_last_read: cover property (tblAccept
        && tblReq.op == TBL_RD_EXT_LAST);
    c_prog_write: cover property (progWrite);
    c_back_to_back: cover property (tblAccept ##2 tblAccept);
endmodule

// ### verif/serial_programmer.sv
`timescale 1ns/1ps

// ----------------------------------------
// programmer side of the serial link
// ----------------------------------------
module serial_programmer (
    // clock
    input wire logic clk,
    // link pins
    output logic progMode,
    output logic serClk,
    output logic serData,
    // read-back from the device
    input wire logic serIn,
    input wire logic serOe
);
    initial begin
        progMode = 1'b0;
        serClk = 1'b0;
        serData = 1'b0;
    end

    // 8 clk per link period; link clock stands still between frames
    // read-back bits are taken where the clock rises, one clk after the
    // device has moved them on the falling edge
    task automatic runFrame(input logic [29:0] frame, output logic [15:0] w,
        output logic oeAll);
        w = 16'h0000;
        oeAll = 1'b1;
        @(posedge clk);
        progMode <= 1'b1;
        for (int i = 29; i >= 0; i--) begin
            repeat (4) @(posedge clk);
            serClk <= 1'b0;
            serData <= frame[i];
            repeat (4) @(posedge clk);
            serClk <= 1'b1;
            if (i < 16) begin
                w[i] = serIn;
                oeAll = oeAll && serOe;
            end
        end
        repeat (4) @(posedge clk);
        serClk <= 1'b0;
        // no pull on the line: show the inverse once released
        serData <= ~frame[0];
        repeat (8) @(posedge clk);
        progMode <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic writeWord(input logic [12:0] addr, input logic [15:0] w);
        logic [15:0] unusedWord;
        logic unusedOe;
        runFrame({1'b1, addr, w}, unusedWord, unusedOe);
    endtask

    task automatic readWord(input logic [12:0] addr, output logic [15:0] w,
        output logic oeAll);
        runFrame({1'b0, addr, 16'h0000}, w, oeAll);
    endtask
endmodule

// ### verif/program_memory_table_read_tb_top.sv
`timescale 1ns/1ps

module program_memory_table_read_tb_top;
    import pmem_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic pcAdvance = 1'b0;
    logic pcLoad = 1'b0;
    logic [12:0] pcLoadValue = 13'h0000;
    logic [12:0] pc_q;
    logic [15:0] instrWord_q;
    tblReq_s tblReq = '0;
    logic [7:0] tblPtrLow = 8'h00;
    logic [7:0] tblPtrHigh = 8'h00;
    logic tblBusy_q;
    dmWrite_s dmWr_q;
    logic highByteWrEn = 1'b0;
    logic [7:0] highByteWrData = 8'h00;
    logic [7:0] tableHighByte_q;
    logic useDebugPins = 1'b0;
    logic progMode, serClk, serData, serialDataOut_q, serialDataOe_q;
    logic progClk;
    logic dbgClk;
    int num_errors = 0;
    int compares = 0;

    always #20 clk = ~clk;

    // only the selected pin pair sees the link clock
    assign progClk = serClk && !useDebugPins;
    assign dbgClk = serClk && useDebugPins;

    program_memory_table_read DUT (
        .clk(clk), .rst_n(rst_n),
        .pcAdvance(pcAdvance), .pcLoad(pcLoad), .pcLoadValue(pcLoadValue),
        .pc_q(pc_q), .instrWord_q(instrWord_q),
        .tblReq(tblReq), .tblPtrLow(tblPtrLow), .tblPtrHigh(tblPtrHigh),
        .tblBusy_q(tblBusy_q), .dmWr_q(dmWr_q),
        .highByteWrEn(highByteWrEn), .highByteWrData(highByteWrData),
        .tableHighByte_q(tableHighByte_q),
        .progMode(progMode), .useDebugPins(useDebugPins),
        .prog_serial_clock(progClk), .prog_serial_data_in(serData),
        .debug_serial_clock(dbgClk), .debug_serial_data_in(serData),
        .serialDataOut_q(serialDataOut_q), .serialDataOe_q(serialDataOe_q)
    );

    serial_programmer prog (
        .clk(clk), .progMode(progMode), .serClk(serClk), .serData(serData),
        .serIn(serialDataOut_q), .serOe(serialDataOe_q)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [17:0] got, exp, input string what);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h exp %h",
                $time, what, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic tblRead(input tblop_e op, input logic [8:0] dest,
        input logic [7:0] lo, hi, input logic [8:0] ea, input logic [15:0] w,
        input logic hold);
        @(posedge clk);
        tblPtrLow <= lo;
        tblPtrHigh <= hi;
        tblReq <= '{1'b1, op, dest};
        @(posedge clk);
        // a held request meets the busy cycle and must be ignored
        if (!hold)
            tblReq <= '0;
        #1 chk(dmWr_q.en, 1'b0, "early write");
        chk(tblBusy_q, 1'b1, "busy");
        @(posedge clk);
        tblReq <= '0;
        #1 chk(dmWr_q, {1'b1, ea, w[7:0]}, "low byte");
        chk(tableHighByte_q, w[15:8], "high byte");
        chk(tblBusy_q, 1'b0, "busy end");
        @(posedge clk);
        #1 chk(dmWr_q.en, 1'b0, "write pulse");
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_pc();
        #1 chk(pc_q, 13'h0000, "pc after reset");
        @(posedge clk);
        pcLoad <= 1'b1;
        pcLoadValue <= 13'h1FFF;
        @(posedge clk);
        pcLoad <= 1'b0;
        pcAdvance <= 1'b1;
        #1 chk(pc_q, 13'h1FFF, "pc load");
        @(posedge clk);
        pcAdvance <= 1'b0;
        #1 chk(pc_q, 13'h0000, "pc wrap");
        $display("test_pc done");
    endtask

    task automatic test_program();
        logic [15:0] readBack;
        logic oeAll;
        prog.writeWord(13'h0000, 16'h1234);
        useDebugPins <= 1'b1;
        prog.writeWord(13'h1F06, 16'hA51A);
        useDebugPins <= 1'b0;
        prog.writeWord(13'h0203, 16'h3C0F);
        prog.readWord(13'h0203, readBack, oeAll);
        chk(readBack, 16'h3C0F, "read back");
        chk(oeAll, 1'b1, "line driven");
        #1 chk(serialDataOe_q, 1'b0, "line released");
        // move the fetch away from 000H so the reset has work to do
        @(posedge clk);
        pcLoad <= 1'b1;
        pcLoadValue <= 13'h0203;
        @(posedge clk);
        pcLoad <= 1'b0;
        @(posedge clk);
        #1 chk(instrWord_q, 16'h3C0F, "fetch");
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk(instrWord_q, 16'h1234, "reset entry");
        chk(pc_q, 13'h0000, "pc reset entry");
        $display("test_program done");
    endtask

    task automatic test_tables();
        // sector bit dropped on standard reads, kept on extended ones
        tblRead(TBL_RD, 9'h1C5, 8'h03, 8'h02, 9'h0C5, 16'h3C0F,
            1'b0);
        tblRead(TBL_RD_LAST, 9'h045, 8'h06, 8'h02, 9'h045, 16'hA51A,
            1'b0);
        tblRead(TBL_RD_EXT, 9'h1C5, 8'h03, 8'hE2, 9'h1C5, 16'h3C0F,
            1'b1);
        tblRead(TBL_RD_EXT_LAST, 9'h100, 8'h06, 8'h00, 9'h100, 16'hA51A,
            1'b0);
        $display("test_tables done");
    endtask

    task automatic test_high_byte();
        @(posedge clk);
        highByteWrEn <= 1'b1;
        highByteWrData <= 8'h5A;
        @(posedge clk);
        highByteWrEn <= 1'b0;
        #1 chk(tableHighByte_q, 8'h5A, "sw write");
        $display("test_high_byte done");
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        test_pc();
        test_program();
        test_tables();
        test_high_byte();
        stop_test();
    end

    // whole run is about 1100 cycles; allow over four times that
    initial begin
        #200000;
        num_errors++;
        stop_test();
    end
endmodule
